// ---- hw/sma_spi_slave.sv ----
// serial memory-access slave port: link shifter, command FIFO and memory sequencer
`include "sma_params.svh"
`default_nettype none

// ----------------------------------------------------------------
// command FIFO
// ----------------------------------------------------------------
module sma_fifo #(
	parameter int WIDTH = `SMA_FRAME_BITS,
	parameter int DEPTH = `SMA_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic             ce,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [PW:0]      count_r;
	logic             push;
	logic             pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : ptr_inc

	assign in_ready  = (count_r != (PW + 1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem_r[rd_ptr_r];
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= ptr_inc(wr_ptr_r);
			end
			if (pop) begin
				rd_ptr_r <= ptr_inc(rd_ptr_r);
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule : sma_fifo

// ----------------------------------------------------------------
// top: slave port
// ----------------------------------------------------------------
module sma_spi_slave
	import sma_pkg::*;
#(
	parameter int FIFO_DEPTH = `SMA_FIFO_DEPTH
) (
	// system clock and reset
	input  wire logic                          clock,
	input  wire logic                          reset_n,
	input  wire logic                          ce,
	// serial link pins
	input  wire logic                          sck,
	input  wire logic                          cs_n,
	input  wire logic                          mosi,
	output logic                               miso_o,
	output logic                               miso_oe,
	// control inputs from the test and interface registers
	input  wire logic                          if_select,
	input  wire logic                          onewire_transceiver_enable,
	input  wire logic [1:0]                    digital_interface_control,
	// output path controls
	output logic                               transceiver_on_r,
	output logic                               pin_to_analogue_r,
	output logic                               analogue_driver_en_r,
	output logic                               i2c_select_r,
	output logic                               spi_select_r,
	// memory port
	output logic                               mem_valid_r,
	input  wire logic                          mem_ready,
	output var sma_page_t                      mem_page_r,
	output logic      [`SMA_MEM_ADDR_BITS-1:0] mem_addr_r,
	output logic                               mem_write_r,
	output logic      [7:0]                    mem_wdata_r,
	input  wire logic                          mem_rvalid,
	input  wire logic [7:0]                    mem_rdata,
	// status
	output logic                               busy_r,
	output logic                               denied_r,
	output logic                               dropped_r
);
	// ------------------------------------------------------------
	// link domain
	// ------------------------------------------------------------
	logic [4:0]                    bit_cnt_r;
	logic [`SMA_FRAME_BITS-2:0]    shin_r;
	logic [`SMA_FRAME_BITS-1:0]    frame_r;
	logic                          frame_tgl_r;
	logic [7:0]                    resp_byte_r;
	logic [`SMA_FRAME_BITS-1:0]    resp_word;

	assign resp_word = {12'h000, resp_byte_r, 4'h0};

	// chip select high holds the whole shifter in reset
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_r <= 5'h00;
			shin_r    <= '0;
			miso_o    <= 1'b0;
			miso_oe   <= 1'b0;
		end else begin
			miso_oe <= 1'b1;
			if (bit_cnt_r != `SMA_FRAME_BITS) begin
				bit_cnt_r <= bit_cnt_r + 5'h01;
				shin_r    <= {shin_r[`SMA_FRAME_BITS-3:0], mosi};
			end
			// reply byte is only looked at from bit 11 on, long after the frame opened
			if (bit_cnt_r < `SMA_LAST_BIT) begin
				miso_o <= resp_word[5'h16 - bit_cnt_r];
			end else begin
				miso_o <= 1'b0;
			end
		end
	end

	// the captured frame and its toggle survive chip select; only system reset clears them
	always_ff @(posedge sck or negedge reset_n) begin
		if (!reset_n) begin
			frame_r     <= '0;
			frame_tgl_r <= 1'b0;
		end else if (!cs_n && bit_cnt_r == `SMA_LAST_BIT) begin
			frame_r     <= {shin_r, mosi};
			frame_tgl_r <= ~frame_tgl_r;
		end
	end

	// ------------------------------------------------------------
	// crossing into the system domain
	// ------------------------------------------------------------
	logic tgl_s1_r;
	logic tgl_s2_r;
	logic tgl_seen_r;
	logic cs_s1_r;
	logic cs_s2_r;
	logic new_frame;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			tgl_s1_r   <= 1'b0;
			tgl_s2_r   <= 1'b0;
			tgl_seen_r <= 1'b0;
			cs_s1_r    <= 1'b1;
			cs_s2_r    <= 1'b1;
		end else if (ce) begin
			tgl_s1_r   <= frame_tgl_r;
			tgl_s2_r   <= tgl_s1_r;
			tgl_seen_r <= tgl_s2_r;
			cs_s1_r    <= cs_n;
			cs_s2_r    <= cs_s1_r;
		end
	end

	assign new_frame = ce && (tgl_s2_r != tgl_seen_r);

	// ------------------------------------------------------------
	// frame holding stage and FIFO
	// ------------------------------------------------------------
	logic                       cmd_valid_r;
	logic [`SMA_FRAME_BITS-1:0] cmd_word_r;
	logic                       fifo_in_ready;
	logic                       fifo_out_valid;
	logic                       fifo_out_ready;
	logic [`SMA_FRAME_BITS-1:0] fifo_out_data;

	// a full FIFO stalls the holding stage; a frame arriving then is lost and flagged
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			cmd_valid_r <= 1'b0;
			cmd_word_r  <= '0;
			dropped_r   <= 1'b0;
		end else if (ce) begin
			dropped_r <= 1'b0;
			if (new_frame) begin
				if (cmd_valid_r && !fifo_in_ready) begin
					dropped_r <= 1'b1;
				end else begin
					cmd_word_r  <= frame_r;
					cmd_valid_r <= 1'b1;
				end
			end else if (cmd_valid_r && fifo_in_ready) begin
				cmd_valid_r <= 1'b0;
			end
		end
	end

	sma_fifo #(
		.WIDTH (`SMA_FRAME_BITS),
		.DEPTH (FIFO_DEPTH)
	) i_sma_fifo (
		.clock     (clock),
		.reset_n   (reset_n),
		.ce        (ce),
		.in_valid  (cmd_valid_r),
		.in_ready  (fifo_in_ready),
		.in_data   (cmd_word_r),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// ------------------------------------------------------------
	// command decode and memory sequencer
	// ------------------------------------------------------------
	sma_state_t                     state_r;
	logic [`SMA_OTP_HI_BITS-1:0]    otp_hi_r;
	sma_page_t                      cmd_page;
	logic                           cmd_write;
	logic                           cmd_allowed;
	logic                           pop;
	logic                           res_set;
	logic [7:0]                     res_val;

	function automatic logic page_allowed(input sma_page_t p, input logic sel);
		unique case (p)
			PAGE_TEST:                               page_allowed = 1'b1;
			PAGE_PAGE_INTERNAL_RAM, PAGE_XSFR, PAGE_OTP, PAGE_EE_CACHE: page_allowed = sel;
			default:                                 page_allowed = 1'b0;
		endcase
	endfunction : page_allowed

	assign fifo_out_ready = (state_r == ST_IDLE);
	assign pop            = ce && fifo_out_valid && fifo_out_ready;
	assign cmd_page       = sma_page_t'(fifo_out_data[`SMA_PAGE_HI:`SMA_PAGE_LO]);
	assign cmd_write      = fifo_out_data[`SMA_RW_BIT];
	assign cmd_allowed    = page_allowed(cmd_page, if_select);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_r     <= ST_IDLE;
			otp_hi_r    <= '0;
			mem_valid_r <= 1'b0;
			mem_page_r  <= PAGE_TEST;
			mem_addr_r  <= '0;
			mem_write_r <= 1'b0;
			mem_wdata_r <= 8'h00;
			denied_r    <= 1'b0;
		end else if (ce) begin
			denied_r <= 1'b0;
			unique case (state_r)
				ST_IDLE: begin
					if (pop) begin
						if (cmd_page == PAGE_OTP_HIGH) begin
							otp_hi_r <= fifo_out_data[`SMA_DATA_LO+`SMA_OTP_HI_BITS-1:`SMA_DATA_LO];
						end else if (cmd_allowed) begin
							mem_valid_r <= 1'b1;
							mem_page_r  <= cmd_page;
							mem_write_r <= cmd_write;
							mem_wdata_r <= fifo_out_data[`SMA_DATA_HI:`SMA_DATA_LO];
							mem_addr_r  <= (cmd_page == PAGE_OTP) ?
								{otp_hi_r, fifo_out_data[`SMA_ADDR_HI:`SMA_ADDR_LO]} :
								{5'h00, fifo_out_data[`SMA_ADDR_HI:`SMA_ADDR_LO]};
							state_r     <= ST_REQ;
						end else begin
							denied_r <= 1'b1;
						end
					end
				end
				ST_REQ: begin
					if (mem_ready) begin
						mem_valid_r <= 1'b0;
						state_r     <= mem_write_r ? ST_IDLE : ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (mem_rvalid) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// every taken command leaves a reply byte: read data, or zero for anything else
	always_comb begin
		res_set = 1'b0;
		res_val = 8'h00;
		if (state_r == ST_IDLE && pop && !(cmd_allowed && cmd_page != PAGE_OTP_HIGH)) begin
			res_set = 1'b1;
		end else if (state_r == ST_REQ && mem_ready && mem_write_r) begin
			res_set = 1'b1;
		end else if (state_r == ST_WAIT && mem_rvalid) begin
			res_set = 1'b1;
			res_val = mem_rdata;
		end
	end

	// ------------------------------------------------------------
	// reply hand-off: only while chip select idles, so the shifter sees a steady byte
	// ------------------------------------------------------------
	logic [7:0] result_r;
	logic       result_new_r;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			result_r     <= 8'h00;
			result_new_r <= 1'b0;
			resp_byte_r  <= 8'h00;
			busy_r       <= 1'b0;
		end else if (ce) begin
			busy_r <= (state_r != ST_IDLE) || fifo_out_valid || cmd_valid_r;
			if (result_new_r && cs_s2_r) begin
				resp_byte_r <= result_r;
			end
			// a new result in the hand-off cycle is kept: the set wins
			if (res_set) begin
				result_r     <= res_val;
				result_new_r <= 1'b1;
			end else if (cs_s2_r) begin
				result_new_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// output pin routing and interface choice
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			transceiver_on_r     <= 1'b0;
			pin_to_analogue_r    <= 1'b1;
			analogue_driver_en_r <= 1'b1;
			i2c_select_r         <= 1'b0;
			spi_select_r         <= 1'b1;
		end else if (ce) begin
			transceiver_on_r     <= onewire_transceiver_enable;
			pin_to_analogue_r    <= !onewire_transceiver_enable;
			analogue_driver_en_r <= (digital_interface_control != `SMA_DI_ONEWIRE);
			i2c_select_r         <= (digital_interface_control == `SMA_DI_I2C);
			spi_select_r         <= (digital_interface_control != `SMA_DI_I2C) &&
			                        (digital_interface_control != `SMA_DI_ONEWIRE);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence s_pop_blocked;
		pop && !cmd_allowed && cmd_page != PAGE_OTP_HIGH;
	endsequence

	sequence s_read_done;
		ce && state_r == ST_WAIT && mem_rvalid;
	endsequence

	a_page_gate: assert property (s_pop_blocked |=> !mem_valid_r && denied_r)
		else $error("blocked page started a memory access");

	a_spare_nowrite: assert property (mem_valid_r |-> mem_page_r != PAGE_SPARE6 &&
		mem_page_r != PAGE_SPARE7 && (if_select || mem_page_r == PAGE_TEST))
		else $error("memory access on an unassigned or gated page");

	a_otp_address: assert property (mem_valid_r && mem_page_r == PAGE_OTP
		|-> mem_addr_r[`SMA_MEM_ADDR_BITS-1:8] == otp_hi_r)
		else $error("program address high bits not applied");

	a_one_request: assert property (ce && mem_valid_r && mem_ready |=>
		!mem_valid_r ##1 (!mem_valid_r || $past(pop)))
		else $error("more than one access for one command");

	a_read_result: assert property (s_read_done |=>
		result_new_r && result_r == $past(mem_rdata))
		else $error("read data not kept for the reply");

	a_reply_idle: assert property (ce && !cs_s2_r |=> resp_byte_r == $past(resp_byte_r))
		else $error("reply byte changed during a frame");

	a_out_tristate: assert property (cs_n |-> !miso_oe)
		else $error("serial output driven while deselected");

	a_xcvr_off: assert property (ce && !onewire_transceiver_enable
		|=> !transceiver_on_r && pin_to_analogue_r)
		else $error("transceiver not released");

	a_analog_on: assert property (ce && digital_interface_control != `SMA_DI_ONEWIRE
		|=> analogue_driver_en_r && (i2c_select_r || spi_select_r))
		else $error("analogue driver not enabled");

	a_i2c_pick: assert property (ce && digital_interface_control == `SMA_DI_I2C
		|=> i2c_select_r && !spi_select_r)
		else $error("I2C not selected");

	a_reply_zeros: assert property (@(posedge sck) disable iff (cs_n)
		(bit_cnt_r < 5'h0B) || (bit_cnt_r >= `SMA_REPLY_LOW_ZERO && bit_cnt_r < `SMA_LAST_BIT)
		|=> !miso_o)
		else $error("reply padding bit not zero");

endmodule : sma_spi_slave

`default_nettype wire

// ---- hw/sma_params.svh ----
// constants of the serial memory-access slave port
//
// Behaviour
// - the port is only a slave; the external master starts every frame.
// - frames shift most significant bit first on both data lines.
// - chip select low opens a frame; chip select high holds the link shifter in reset.
// - while chip select is high the serial output is not driven.
// - a frame is 24 bits: page, address, write flag, data, four spare bits.
// - page 011 loads program address high bits; page 100 accesses that location.
// - page 101 reaches the EEPROM cache; the master selects the bank first.
// - write flag 1 writes the data byte; flag 0 reads and ignores data.
// - read data comes back during the next frame.
// - each read command returns exactly one byte, never a burst.
// - the reply holds data in bits 11:4 and zeros in every other bit.
// - input bits are captured on the rising serial clock edge.
// - the output bit changes on each rising serial clock edge.
// - clearing the one-wire enable turns the transceiver off, pin to analogue driver.
// - interface select other than 10 re-enables the analogue output driver.
// - interface select 01 picks the I2C interface.
`ifndef SMA_PARAMS_SVH
`define SMA_PARAMS_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define SMA_FRAME_BITS     24
`define SMA_PAGE_HI        23
`define SMA_PAGE_LO        21
`define SMA_ADDR_HI        20
`define SMA_ADDR_LO        13
`define SMA_RW_BIT         12
`define SMA_DATA_HI        11
`define SMA_DATA_LO        4
`define SMA_LAST_BIT       5'h17
`define SMA_REPLY_LOW_ZERO 5'h13

// ----------------------------------------------------------------
// program memory address and buffering
// ----------------------------------------------------------------
`define SMA_OTP_HI_BITS    5
`define SMA_MEM_ADDR_BITS  13
`define SMA_FIFO_DEPTH     32

// ----------------------------------------------------------------
// digital interface select codes
// ----------------------------------------------------------------
`define SMA_DI_ONEWIRE     2'h2
`define SMA_DI_I2C         2'h1

`endif

// ---- hw/sma_pkg.sv ----
// types shared by the serial memory-access slave port
`default_nettype none

package sma_pkg;

	typedef enum logic [2:0] {
		PAGE_TEST      = 3'h0,
		PAGE_PAGE_INTERNAL_RAM      = 3'h1,
		PAGE_XSFR      = 3'h2,
		PAGE_OTP_HIGH  = 3'h3,
		PAGE_OTP       = 3'h4,
		PAGE_EE_CACHE  = 3'h5,
		PAGE_SPARE6    = 3'h6,
		PAGE_SPARE7    = 3'h7
	} sma_page_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_REQ  = 3'h2,
		ST_WAIT = 3'h4
	} sma_state_t;

endpackage : sma_pkg

`default_nettype wire

// ---- dv/sma_spi_master.sv ----
// behavioural serial master that drives frames into the slave port
`default_nettype none

module sma_spi_master (
	// link pins
	output var logic sck,
	output var logic cs_n,
	output var logic mosi,
	input  wire logic miso_o,
	input  wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sck = 1'b0;
		// non-blocking so the shifter sees the rising edge that resets it
		cs_n <= 1'b1;
		mosi = 1'b0;
	end

	// ----------------------------------------------------------------
	// frame transfer
	// ----------------------------------------------------------------
	// sck runs at 6 ns only inside a frame; nbits below 24 cuts the frame short
	task automatic xfer(input logic [23:0] cmd, input int nbits, output logic [23:0] rsp);
		rsp = 24'h000000;
		#1.3;
		cs_n = 1'b0;
		mosi = cmd[23];
		#3;
		rsp[23] = miso_o;
		for (int k = 0; k < nbits; k++) begin
			sck = 1'b1;
			#3;
			sck = 1'b0;
			if (k < 23) begin
				rsp[22-k] = miso_o;
				mosi = cmd[22-k];
			end
			#3;
		end
		cs_n = 1'b1;
		// idle line shows the inverse so a stale bit is never mistaken for data
		mosi = ~mosi;
	endtask : xfer

endmodule : sma_spi_master

`default_nettype wire

// ---- dv/tb_sma_spi_slave.sv ----
// self-checking bench of the serial memory-access slave port
`include "sma_params.svh"
`default_nettype none

module tb_sma_spi_slave
	import sma_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clock = 1'b0, reset_n = 1'b1, ce = 1'b1, if_select = 1'b0, stall = 1'b0;
	logic onewire_transceiver_enable = 1'b0;
	logic [1:0] digital_interface_control = 2'h0;
	logic sck, cs_n, mosi, miso_o, miso_oe, mem_valid_r, mem_write_r, busy_r, denied_r;
	logic transceiver_on_r, pin_to_analogue_r, analogue_driver_en_r, i2c_select_r;
	logic spi_select_r, dropped_r, mem_ready = 1'b0, mem_rvalid = 1'b0;
	logic [7:0] mem_wdata_r, mem_rdata = 8'h00;
	logic [`SMA_MEM_ADDR_BITS-1:0] mem_addr_r, last_addr;
	sma_page_t mem_page_r, last_page;
	logic [7:0] store [logic [15:0]];
	int fail_count = 0, checks = 0, acc_n = 0, den_n = 0, drop_n = 0;

	always #10 clock = ~clock;

	sma_spi_master i_sma_spi_master (.sck(sck), .cs_n(cs_n), .mosi(mosi),
		.miso_o(miso_o), .miso_oe(miso_oe));

	sma_spi_slave #(.FIFO_DEPTH(4)) i_sma_spi_slave (.clock(clock), .reset_n(reset_n),
		.ce(ce), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
		.if_select(if_select), .onewire_transceiver_enable(onewire_transceiver_enable),
		.digital_interface_control(digital_interface_control),
		.transceiver_on_r(transceiver_on_r), .pin_to_analogue_r(pin_to_analogue_r),
		.analogue_driver_en_r(analogue_driver_en_r), .i2c_select_r(i2c_select_r),
		.spi_select_r(spi_select_r), .mem_valid_r(mem_valid_r), .mem_ready(mem_ready),
		.mem_page_r(mem_page_r), .mem_addr_r(mem_addr_r), .mem_write_r(mem_write_r),
		.mem_wdata_r(mem_wdata_r), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
		.busy_r(busy_r), .denied_r(denied_r), .dropped_r(dropped_r));

	// ----------------------------------------------------------------
	// memory responder and pulse counters
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		mem_rvalid <= 1'b0;
		if (denied_r === 1'b1) den_n++;
		if (dropped_r === 1'b1) drop_n++;
		if (mem_valid_r === 1'b1 && mem_ready === 1'b1) begin
			mem_ready <= 1'b0;
			acc_n++;
			last_addr <= mem_addr_r;
			last_page <= mem_page_r;
			if (mem_write_r === 1'b1) begin
				store[{mem_page_r, mem_addr_r}] = mem_wdata_r;
			end else begin
				mem_rvalid <= 1'b1;
				mem_rdata <= store.exists({mem_page_r, mem_addr_r}) ?
					store[{mem_page_r, mem_addr_r}] : 8'hA5;
			end
		end else if (mem_valid_r === 1'b1 && stall === 1'b0) begin
			mem_ready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [23:0] cmd(sma_page_t p, logic [7:0] a, logic w, logic [7:0] d);
		return {p, a, w, d, 4'h0};
	endfunction : cmd

	task automatic frame(input logic [23:0] c, output logic [23:0] rsp);
		int n;
		n = 0;
		i_sma_spi_master.xfer(c, 24, rsp);
		// busy only rises once the frame has crossed and been queued
		repeat (6) @(posedge clock);
		chk(miso_oe, 1'b0);
		@(negedge clock);
		while (busy_r !== 1'b0 && n < 300) begin
			@(negedge clock);
			n++;
		end
		if (n >= 300) chk(busy_r, 1'b0);
		repeat (4) @(posedge clock);
	endtask : frame

	task automatic end_sim();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk({miso_oe, mem_valid_r, pin_to_analogue_r, analogue_driver_en_r, spi_select_r,
			i2c_select_r, transceiver_on_r}, 7'b0011100);
	endtask : t_reset

	task automatic t_pages();
		logic [23:0] r;
		sma_page_t pg [4] = '{PAGE_TEST, PAGE_PAGE_INTERNAL_RAM, PAGE_XSFR, PAGE_EE_CACHE};
		@(posedge clock);
		if_select <= 1'b1;
		frame(cmd(PAGE_TEST, 8'h0B, 1'b1, 8'h04), r);
		foreach (pg[i]) begin
			frame(cmd(pg[i], 8'(8'h40 + i), 1'b1, 8'(8'h31 + i)), r);
			chk(r, 24'h0);
			chk({last_page, last_addr}, {pg[i], 13'(8'h40 + i)});
			frame(cmd(pg[i], 8'(8'h40 + i), 1'b0, 8'hFF), r);
			frame(cmd(PAGE_TEST, 8'hFF, 1'b1, 8'h00), r);
			chk(r, {12'h000, 8'(8'h31 + i), 4'h0});
		end
	endtask : t_pages

	task automatic t_otp();
		logic [23:0] r;
		int a;
		a = acc_n;
		frame(cmd(PAGE_OTP_HIGH, 8'h00, 1'b1, 8'h17), r);
		chk(acc_n, a);
		frame(cmd(PAGE_OTP, 8'h65, 1'b1, 8'hD9), r);
		chk({last_page, last_addr}, {PAGE_OTP, 13'h1765});
		frame(cmd(PAGE_OTP, 8'h65, 1'b0, 8'h00), r);
		frame(cmd(PAGE_TEST, 8'hFF, 1'b1, 8'h00), r);
		chk(r, {12'h000, 8'hD9, 4'h0});
	endtask : t_otp

	task automatic t_refused();
		logic [23:0] r;
		int a, d;
		a = acc_n;
		d = den_n;
		@(posedge clock);
		if_select <= 1'b0;
		frame(cmd(PAGE_PAGE_INTERNAL_RAM, 8'h10, 1'b1, 8'h55), r);
		chk(acc_n, a);
		chk(den_n, d + 1);
		frame(cmd(PAGE_TEST, 8'h10, 1'b1, 8'h55), r);
		chk(acc_n, a + 1);
		@(posedge clock);
		if_select <= 1'b1;
		frame(cmd(PAGE_SPARE6, 8'h10, 1'b1, 8'h55), r);
		// a nonzero read first, so a missing zero reply on the spare page shows
		frame(cmd(PAGE_PAGE_INTERNAL_RAM, 8'h41, 1'b0, 8'h00), r);
		frame(cmd(PAGE_SPARE7, 8'h10, 1'b0, 8'h00), r);
		chk(r, 24'h000320);
		i_sma_spi_master.xfer(cmd(PAGE_PAGE_INTERNAL_RAM, 8'h11, 1'b1, 8'h66), 12, r);
		repeat (4) @(posedge clock);
		frame(cmd(PAGE_TEST, 8'hFF, 1'b1, 8'h00), r);
		chk(r, 24'h0);
		chk(acc_n, a + 3);
		chk(den_n, d + 3);
	endtask : t_refused

	task automatic t_modes();
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			{onewire_transceiver_enable, digital_interface_control} <= i[2:0];
			repeat (3) @(posedge clock);
			chk({transceiver_on_r, pin_to_analogue_r, analogue_driver_en_r, i2c_select_r,
				spi_select_r}, {i[2], !i[2], i[1:0] != 2'h2, i[1:0] == 2'h1,
				i[1:0] == 2'h0 || i[1:0] == 2'h3});
		end
		// with the clock enable low the routing must not follow the inputs
		@(posedge clock);
		ce <= 1'b0;
		{onewire_transceiver_enable, digital_interface_control} <= 3'h2;
		repeat (3) @(posedge clock);
		chk({transceiver_on_r, analogue_driver_en_r}, 2'b11);
		ce <= 1'b1;
		repeat (3) @(posedge clock);
		chk({transceiver_on_r, analogue_driver_en_r}, 2'b00);
	endtask : t_modes

	task automatic t_fill();
		logic [23:0] r;
		int a;
		a = acc_n;
		@(posedge clock);
		stall <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			i_sma_spi_master.xfer(cmd(PAGE_PAGE_INTERNAL_RAM, i[7:0], 1'b1, 8'h70), 24, r);
		end
		@(posedge clock);
		stall <= 1'b0;
		frame(cmd(PAGE_PAGE_INTERNAL_RAM, 8'h20, 1'b1, 8'h71), r);
		chk(drop_n != 0, 1'b1);
		chk(acc_n - a + drop_n, 13);
	endtask : t_fill

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		// a real falling edge, so the link-side capture register is cleared too
		reset_n <= 1'b0;
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		repeat (3) @(posedge clock);
		t_reset();
		t_pages();
		t_otp();
		t_refused();
		t_modes();
		t_fill();
		end_sim();
	end

	initial begin
		#200000;
		fail_count++;
		$display("Error at %0t: watchdog expired", $time);
		end_sim();
	end

endmodule : tb_sma_spi_slave

`default_nettype wire
